// [rtl/pcc_pkg.sv]
package pcc_pkg;

   // ----------------------------------------------------------------
   // Register location and layout
   // ----------------------------------------------------------------
   localparam logic [7:0] PLL_CLOCK_CONTROL_ADDR = 8'hD7;
   localparam logic [7:0] PLL_CLOCK_CONTROL_RST  = 8'h03;
   localparam logic [7:0] UNMAPPED_READ_VALUE    = 8'h00;
   localparam int         CRYSTAL_HALT_BIT       = 7;
   localparam int         LOCK_BIT               = 6;
   localparam int         RESERVED_BIT           = 5;
   localparam int         EXT_ACCESS_BIT         = 4;
   localparam int         FAST_IRQ_BIT           = 3;
   localparam int         DIV_MSB                = 2;
   localparam int         DIV_LSB                = 0;
   localparam int         DIV_W                  = 3;

   // ----------------------------------------------------------------
   // Clock plan
   // ----------------------------------------------------------------
   localparam int         PLL_MULTIPLIER         = 384;
   localparam int         CRYSTAL_HZ             = 32768;
   localparam int         PLL_HZ                 = PLL_MULTIPLIER * CRYSTAL_HZ;
   localparam logic [2:0] DIV_FASTEST            = 3'h0;
   localparam int         DIV_CNT_W              = 7;

   // Software-visible control bits held in flops
   typedef struct packed {
      logic             crystal_halt_in_sleep;
      logic             fast_irq_response;
      logic [DIV_W-1:0] core_div;
   } pcc_ctrl_t;

endpackage : pcc_pkg

// [rtl/pcc_core_div.sv]
`timescale 1ns/100ps

// Core clock enable divider: one pulse every 2**div_sel cycles.
// A new setting is taken only on a pulse of the current one and the
// count restarts there, so no period is ever cut short.
module pcc_core_div #(
   parameter int DIV_W = pcc_pkg::DIV_W,
   parameter int CNT_W = pcc_pkg::DIV_CNT_W
) (
   input  wire logic             clk,
   input  wire logic             rst_n,
   input  wire logic             run,
   input  wire logic [DIV_W-1:0] div_sel,
   output logic                  pulse
);

   typedef struct packed {
      logic [DIV_W-1:0] div;
      logic [CNT_W-1:0] cnt;
      logic             pulse;
   } pcc_div_state_t;

   pcc_div_state_t s_q;
   pcc_div_state_t s_d;
   logic           wrap;

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      logic [CNT_W-1:0] last;
      last  = CNT_W'((1 << s_q.div) - 1);
      s_d   = s_q;
      wrap  = (s_q.cnt >= last);
      s_d.pulse = 1'b0;
      if (run) begin
         if (wrap) begin
            s_d.pulse = 1'b1;
            s_d.cnt   = '0;
            s_d.div   = div_sel;
         end else begin
            s_d.cnt = s_q.cnt + CNT_W'(1);
         end
      end
   end

   // State register
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s_q <= '{div: pcc_pkg::PLL_CLOCK_CONTROL_RST[2:0], cnt: '0, pulse: 1'b0};
      end else begin
         s_q <= s_d;
      end
   end

   assign pulse = s_q.pulse;

endmodule // pcc_core_div

// [rtl/pcc_clock_control.sv]
`timescale 1ns/100ps

// Behaviour
// - Halt bit set stops the crystal in power-down; clear keeps it running.
// - While the crystal runs in power-down the interval counter stays clocked.
// - Lock bit reads one while the PLL tracks the crystal.
// - Lock bit reads zero whenever the PLL is not tracking.
// - External-access bit returns the pin level caught at reset.
// - Fast interrupt bit runs interrupt service at the fastest core clock.
// - After the interrupt returns the core goes back to the divider setting.
// - Bits two to zero form the three-bit core clock divider.
// - Core clock is PLL clock over two to the divider; default 011.
// - PLL runs at 384 times the crystal; divider starts from it.
// - Register loads 03H at power-on.
module pcc_clock_control (
   input  wire logic       SYS_CLK,
   input  wire logic       NRST,
   input  wire logic [7:0] SFR_ADDR,
   input  wire logic       SFR_WR,
   input  wire logic [7:0] SFR_WDATA,
   output logic      [7:0] SFR_RDATA,
   input  wire logic       PLL_TRACKING,
   input  wire logic       EXTERNAL_ACCESS_PIN,
   input  wire logic       POWER_DOWN,
   input  wire logic       IRQ_IN_SERVICE,
   output logic            CRYSTAL_RUN,
   output logic            TIME_INTERVAL_COUNTER_RUN,
   output logic            CORE_CLK_EN,
   output logic [2:0]      CORE_DIV_ACTIVE
);

   typedef struct packed {
      pcc_pkg::pcc_ctrl_t ctrl;
      logic [1:0]         lock_sync;
      logic [1:0]         ea_sync;
      logic [1:0]         ea_fill;
      logic               ea_caught;
      logic               latched_ext_access_pin;
      logic [7:0]         rdata;
      logic               crystal_run;
   } pcc_state_t;

   pcc_state_t s_q;
   pcc_state_t s_d;
   logic [1:0] rst_sync_q;
   logic       rst_n;
   logic [2:0] div_eff;
   logic       core_run;

   // ----------------------------------------------------------------
   // Reset release
   // ----------------------------------------------------------------
   // Assert at once, release two edges later to avoid recovery hazards
   always_ff @(posedge SYS_CLK or negedge NRST) begin
      if (!NRST) begin
         rst_sync_q <= 2'b00;
      end else begin
         rst_sync_q <= {rst_sync_q[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_q[1];

   // Builds the byte software sees
   function automatic logic [7:0] pack_reg(input pcc_state_t s);
      logic [7:0] v;
      v = 8'h00;
      v[pcc_pkg::CRYSTAL_HALT_BIT]           = s.ctrl.crystal_halt_in_sleep;
      v[pcc_pkg::LOCK_BIT]                   = s.lock_sync[1];
      v[pcc_pkg::EXT_ACCESS_BIT]             = s.latched_ext_access_pin;
      v[pcc_pkg::FAST_IRQ_BIT]               = s.ctrl.fast_irq_response;
      v[pcc_pkg::DIV_MSB:pcc_pkg::DIV_LSB]   = s.ctrl.core_div;
      return v;
   endfunction

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      s_d = s_q;
      // Tracking and access pins from outside pass two flops first
      s_d.lock_sync = {s_q.lock_sync[0], PLL_TRACKING};
      s_d.ea_sync   = {s_q.ea_sync[0], EXTERNAL_ACCESS_PIN};
      // Fill marker trails the synchroniser, so the reset zeros are never caught
      s_d.ea_fill   = {s_q.ea_fill[0], 1'b1};
      // Pin caught once, after the synchroniser has filled post reset
      if (!s_q.ea_caught && s_q.ea_fill[1]) begin
         s_d.ea_caught              = 1'b1;
         s_d.latched_ext_access_pin = s_q.ea_sync[1];
      end
      // Register write; reserved and read-only bits ignore writes
      if (SFR_WR && SFR_ADDR == pcc_pkg::PLL_CLOCK_CONTROL_ADDR) begin
         s_d.ctrl.crystal_halt_in_sleep = SFR_WDATA[pcc_pkg::CRYSTAL_HALT_BIT];
         s_d.ctrl.fast_irq_response     = SFR_WDATA[pcc_pkg::FAST_IRQ_BIT];
         s_d.ctrl.core_div              = SFR_WDATA[pcc_pkg::DIV_MSB:pcc_pkg::DIV_LSB];
      end
      // Read data registered; unmapped addresses return zero
      if (SFR_ADDR == pcc_pkg::PLL_CLOCK_CONTROL_ADDR) begin
         s_d.rdata = pack_reg(s_q);
      end else begin
         s_d.rdata = pcc_pkg::UNMAPPED_READ_VALUE;
      end
      // Crystal only stops in power-down and only if asked to
      s_d.crystal_run = !(POWER_DOWN && s_q.ctrl.crystal_halt_in_sleep);
   end

   // State register
   always_ff @(posedge SYS_CLK or negedge rst_n) begin
      if (!rst_n) begin
         s_q <= '{ctrl: pcc_pkg::pcc_ctrl_t'(pcc_pkg::PLL_CLOCK_CONTROL_RST[4:0]),
                  lock_sync: 2'b00, ea_sync: 2'b00, ea_fill: 2'b00, ea_caught: 1'b0,
                  latched_ext_access_pin: 1'b0, rdata: 8'h00, crystal_run: 1'b1};
      end else begin
         s_q <= s_d;
      end
   end

   // ----------------------------------------------------------------
   // Core clock selection
   // ----------------------------------------------------------------
   // Fast response overrides the divider only while service is active;
   // dropping IRQ_IN_SERVICE hands control back to the stored field.
   always_comb begin
      if (s_q.ctrl.fast_irq_response && IRQ_IN_SERVICE) begin
         div_eff = pcc_pkg::DIV_FASTEST;
      end else begin
         div_eff = s_q.ctrl.core_div;
      end
   end

   // Core stops in power-down; the count base stands for the PLL clock
   assign core_run = !POWER_DOWN;

   pcc_core_div #(
      .DIV_W (pcc_pkg::DIV_W),
      .CNT_W (pcc_pkg::DIV_CNT_W)
   ) u_core_div (
      .clk     (SYS_CLK),
      .rst_n   (rst_n),
      .run     (core_run),
      .div_sel (div_eff),
      .pulse   (CORE_CLK_EN)
   );

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign SFR_RDATA                 = s_q.rdata;
   assign CRYSTAL_RUN               = s_q.crystal_run;
   assign TIME_INTERVAL_COUNTER_RUN = s_q.crystal_run;
   assign CORE_DIV_ACTIVE           = div_eff;

endmodule // pcc_clock_control

// [tb/pcc_clock_control_sva.sv]
`timescale 1ns/100ps

// ------------------------------------------------------------
// Port checker for the clock control block
// ------------------------------------------------------------
module pcc_clock_control_sva (
   input wire logic       SYS_CLK,
   input wire logic       NRST,
   input wire logic [7:0] SFR_ADDR,
   input wire logic       SFR_WR,
   input wire logic [7:0] SFR_WDATA,
   input wire logic [7:0] SFR_RDATA,
   input wire logic       PLL_TRACKING,
   input wire logic       EXTERNAL_ACCESS_PIN,
   input wire logic       POWER_DOWN,
   input wire logic       IRQ_IN_SERVICE,
   input wire logic       CRYSTAL_RUN,
   input wire logic       TIME_INTERVAL_COUNTER_RUN,
   input wire logic       CORE_CLK_EN,
   input wire logic [2:0] CORE_DIV_ACTIVE
);
   // Age since reset; status bits need a few edges to settle after release
   logic [3:0] age_q;
   always_ff @(posedge SYS_CLK or negedge NRST) begin
      if (!NRST) age_q <= 4'h0;
      else if (age_q != 4'hF) age_q <= age_q + 4'h1;
   end
   default clocking cb @(posedge SYS_CLK);
   endclocking
   default disable iff (!NRST);
   // Register selected on the bus; a plain level so it may join boolean terms
   logic sel_w;
   assign sel_w = (SFR_ADDR == pcc_pkg::PLL_CLOCK_CONTROL_ADDR);
   sequence sel_s;
      sel_w;
   endsequence
   sequence trk_hi_s;
      (age_q == 4'hF && PLL_TRACKING) [*4] ##0 sel_s;
   endsequence
   sequence trk_lo_s;
      (age_q == 4'hF && !PLL_TRACKING) [*4] ##0 sel_s;
   endsequence
   tic_follow_a: assert property (TIME_INTERVAL_COUNTER_RUN == CRYSTAL_RUN)
      else $error("interval counter run differs from crystal run");
   xtal_halt_a: assert property (!CRYSTAL_RUN |-> $past(POWER_DOWN))
      else $error("crystal stopped outside power-down");
   // Back-to-back pulses only when the setting adopted two cycles back was the fastest
   no_runt_a: assert property (CORE_CLK_EN && $past(CORE_CLK_EN) |-> $past(CORE_DIV_ACTIVE, 2) == 3'h0)
      else $error("short core clock period");
   unmapped_read_a: assert property (!sel_w |=> SFR_RDATA == pcc_pkg::UNMAPPED_READ_VALUE)
      else $error("unmapped read not zero");
   reserved_zero_a: assert property (sel_s |=> !SFR_RDATA[pcc_pkg::RESERVED_BIT])
      else $error("reserved bit reads one");
   lock_high_a: assert property (trk_hi_s |=> SFR_RDATA[pcc_pkg::LOCK_BIT])
      else $error("lock bit low while tracking");
   lock_low_a: assert property (trk_lo_s |=> !SFR_RDATA[pcc_pkg::LOCK_BIT])
      else $error("lock bit high while not tracking");
   ext_hold_a: assert property ((age_q == 4'hF && sel_w) [*2] |=> $stable(SFR_RDATA[pcc_pkg::EXT_ACCESS_BIT]))
      else $error("latched access bit changed");
endmodule // pcc_clock_control_sva

bind pcc_clock_control pcc_clock_control_sva i_sva (.SYS_CLK(SYS_CLK), .NRST(NRST), .SFR_ADDR(SFR_ADDR),
   .SFR_WR(SFR_WR), .SFR_WDATA(SFR_WDATA), .SFR_RDATA(SFR_RDATA), .PLL_TRACKING(PLL_TRACKING),
   .EXTERNAL_ACCESS_PIN(EXTERNAL_ACCESS_PIN), .POWER_DOWN(POWER_DOWN), .IRQ_IN_SERVICE(IRQ_IN_SERVICE),
   .CRYSTAL_RUN(CRYSTAL_RUN), .TIME_INTERVAL_COUNTER_RUN(TIME_INTERVAL_COUNTER_RUN),
   .CORE_CLK_EN(CORE_CLK_EN), .CORE_DIV_ACTIVE(CORE_DIV_ACTIVE));

// [tb/tb_pcc_clock_control.sv]
`timescale 1ns/100ps

module tb_pcc_clock_control;
   localparam logic [7:0] A = pcc_pkg::PLL_CLOCK_CONTROL_ADDR;
   logic       SYS_CLK, NRST, SFR_WR, PLL_TRACKING, EXTERNAL_ACCESS_PIN, POWER_DOWN, IRQ_IN_SERVICE;
   logic [7:0] SFR_ADDR, SFR_WDATA, SFR_RDATA, m, v;
   logic       CRYSTAL_RUN, TIME_INTERVAL_COUNTER_RUN, CORE_CLK_EN;
   logic [2:0] CORE_DIV_ACTIVE;
   logic [31:0] rs;
   int         n_fail, checked, g, d;

   pcc_clock_control i_dut (.SYS_CLK(SYS_CLK), .NRST(NRST), .SFR_ADDR(SFR_ADDR), .SFR_WR(SFR_WR),
      .SFR_WDATA(SFR_WDATA), .SFR_RDATA(SFR_RDATA), .PLL_TRACKING(PLL_TRACKING),
      .EXTERNAL_ACCESS_PIN(EXTERNAL_ACCESS_PIN), .POWER_DOWN(POWER_DOWN), .IRQ_IN_SERVICE(IRQ_IN_SERVICE),
      .CRYSTAL_RUN(CRYSTAL_RUN), .TIME_INTERVAL_COUNTER_RUN(TIME_INTERVAL_COUNTER_RUN),
      .CORE_CLK_EN(CORE_CLK_EN), .CORE_DIV_ACTIVE(CORE_DIV_ACTIVE));

   // Free-running system clock
   initial begin
      SYS_CLK = 1'b0;
      forever #5 SYS_CLK = ~SYS_CLK;
   end

   function automatic logic [31:0] xs(logic [31:0] x);
      x ^= x << 13;
      x ^= x >> 17;
      x ^= x << 5;
      return x;
   endfunction

   task automatic chk(string n, logic [7:0] s, logic [7:0] e);
      checked++;
      if (s !== e) begin
         n_fail++;
         $display("[ERR] %s expected %h seen %h", n, e, s);
      end
   endtask

   // Write strobe is one cycle; the model keeps only the writable bits
   task automatic wr(logic [7:0] a, logic [7:0] dat);
      @(negedge SYS_CLK);
      SFR_ADDR = a;
      SFR_WDATA = dat;
      SFR_WR = 1'b1;
      @(negedge SYS_CLK);
      SFR_WR = 1'b0;
      if (a == A) m = dat & 8'h8F;
   endtask

   task automatic rd(logic [7:0] a);
      @(negedge SYS_CLK);
      SFR_ADDR = a;
      @(negedge SYS_CLK);
      v = SFR_RDATA;
   endtask

   // Gap between core clock enables, bounded so a dead divider cannot hang
   task automatic period();
      for (int i = 0; i < 300 && CORE_CLK_EN !== 1'b1; i++) @(negedge SYS_CLK);
      g = 0;
      do begin
         @(negedge SYS_CLK);
         g++;
      end while (CORE_CLK_EN !== 1'b1 && g < 300);
   endtask

   task automatic end_of_test();
      $display("checked %0d n_fail %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask

   // Watchdog well beyond the expected run length
   initial begin
      #300us;
      n_fail++;
      end_of_test();
   end

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      {NRST, SFR_WR, POWER_DOWN, IRQ_IN_SERVICE, SFR_ADDR, SFR_WDATA} = '0;
      {PLL_TRACKING, EXTERNAL_ACCESS_PIN} = 2'b11;
      rs = 32'hdbda;
      m = pcc_pkg::PLL_CLOCK_CONTROL_RST;
      repeat (16) @(negedge SYS_CLK);
      NRST = 1'b1;
      repeat (12) @(negedge SYS_CLK);
      rd(A);
      chk("reset", v, 8'h53);
      EXTERNAL_ACCESS_PIN = 1'b0;
      rd(A);
      chk("latched pin", v, 8'h53);
      PLL_TRACKING = 1'b0;
      repeat (4) @(negedge SYS_CLK);
      rd(A);
      chk("unlocked", v, 8'h13);
      PLL_TRACKING = 1'b1;
      // Every divider code; the second gap is the settled one
      for (d = 0; d < 8; d++) begin
         wr(A, 8'(d));
         period();
         period();
         chk("period", 8'(g), 8'(1 << d));
      end
      wr(A, 8'h0B);
      IRQ_IN_SERVICE = 1'b1;
      period();
      period();
      chk("fast irq", 8'(g), 8'h01);
      chk("fast div", {5'h00, CORE_DIV_ACTIVE}, 8'h00);
      IRQ_IN_SERVICE = 1'b0;
      period();
      period();
      chk("after irq", 8'(g), 8'h08);
      chk("resumed div", {5'h00, CORE_DIV_ACTIVE}, 8'h03);
      repeat (8) begin
         rs = xs(rs);
         wr(rs[8] ? A : rs[23:16], rs[7:0]);
         rd(A);
         chk("register", v, m | 8'h50);
      end
      rd(8'hD6);
      chk("unmapped", v, pcc_pkg::UNMAPPED_READ_VALUE);
      wr(A, 8'h83);
      POWER_DOWN = 1'b1;
      repeat (3) @(negedge SYS_CLK);
      chk("halted", {6'h0, CRYSTAL_RUN, TIME_INTERVAL_COUNTER_RUN}, 8'h00);
      // Software can only write while awake, so leave power-down first
      POWER_DOWN = 1'b0;
      wr(A, 8'h03);
      POWER_DOWN = 1'b1;
      repeat (3) @(negedge SYS_CLK);
      chk("kept running", {6'h0, CRYSTAL_RUN, TIME_INTERVAL_COUNTER_RUN}, 8'h03);
      POWER_DOWN = 1'b0;
      // Second reset with the pin now low: the latched bit must follow it
      NRST = 1'b0;
      m = pcc_pkg::PLL_CLOCK_CONTROL_RST;
      repeat (4) @(negedge SYS_CLK);
      NRST = 1'b1;
      repeat (12) @(negedge SYS_CLK);
      rd(A);
      chk("second reset", v, m | 8'h40);
      end_of_test();
   end
endmodule // tb_pcc_clock_control
